// [include/radio_cal_pkg.sv]
// Constants shared by the radio calibration and synthesizer test control block.
// How it works
// (R01) Crystal-start-half bit halves the crystal oscillator wake period while set.
// (R02) ADC-calibration-done bit is read-only and reads 1 after ADC calibration completes.
// (R03) Fine-calibration enable repeats an RC oscillator fine calibration about every 30 s.
// (R04) A 0-to-1 write of RC force starts a calibration; hardware clears the bit.
// (R05) One RC oscillator calibration lasts 2 ms from start to finish.
// (R06) RC oscillator calibrates by itself when wake-up timer or wake-on-receive is active.
// (R07) Software enables the RC oscillator first; no calibration runs while it is off. A run already under way when it turns off still completes.
// (R08) VCO double-precision bit doubles the VCO calibration measurement interval.
// (R09) Writing VCO force in Idle with PLL on runs one VCO calibration, then clears.
// (R10) Skip bit omits VCO calibration on Idle to TX or RX transitions.
// (R11) Modem test bit 7 bypasses bit clock recovery phase compensation.
// (R12) Modem test bit 6 bypasses slicer phase compensation.
// (R13) Dither-type bit picks a +1/0 dither when low and a +1/-1 dither when high.
// (R14) Software leaves the AFC loop polarity bit at its reset value.
// (R15) Reference-select bit picks the 10 MHz clock at 1 and the PLL clock at 0.
// (R16) Modem test bit 1 inverts the delta-sigma reference clock.
// (R17) Modem test bit 0 swaps the in-phase and quadrature receive channels.
// (R18) Charge pump bits 5 and 4 force the pump continuously up or down.
// (R19) Charge pump bits 2 to 0 select the DC current setting.
// (R20) Charge pump bit 3 puts the pump in DC-offset-only mode.
// (R21) Charge pump bits 7 and 6 drive the detector and divider resets directly.
// (R22) VCO force written outside Idle or with PLL off starts nothing and reads 0.
package radio_cal_pkg;

  // ------------------------------------------------------------------
  // Register offsets and reset values
  // ------------------------------------------------------------------
  localparam logic [6:0] ADDR_CAL   = 7'h55;
  localparam logic [6:0] ADDR_MODEM = 7'h56;
  localparam logic [6:0] ADDR_CP    = 7'h57;
  localparam logic [7:0] CAL_RST    = 8'h04;
  localparam logic [7:0] MODEM_RST  = 8'h00;
  localparam logic [7:0] CP_RST     = 8'h00;
  // Bits 7 and 5 of the calibration register are never stored.
  localparam logic [7:0] CAL_WR_MASK = 8'h5F;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CAL_XHALF  = 6;
  localparam int CAL_ADCDN  = 5;
  localparam int CAL_FINE   = 4;
  localparam int CAL_RCF    = 3;
  localparam int CAL_DP     = 2;
  localparam int CAL_VCOF   = 1;
  localparam int CAL_SKIP   = 0;
  localparam int MT_BCRBYP  = 7;
  localparam int MT_SLCBYP  = 6;
  localparam int MT_DTTYPE  = 5;
  localparam int MT_AFCPOL  = 4;
  localparam int MT_REFSEL  = 2;
  localparam int MT_REFINV  = 1;
  localparam int MT_IQSW    = 0;
  localparam int CP_PFDRST  = 7;
  localparam int CP_FBRST   = 6;
  localparam int CP_UP      = 5;
  localparam int CP_DN      = 4;
  localparam int CP_DCONLY  = 3;
  localparam int CP_CUR_HI  = 2;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam longint CLK_HZ       = 125_000_000;
  localparam longint RC_CAL_MS    = 2;
  localparam longint RC_FINE_S    = 30;
  localparam longint VCO_MEAS_US  = 10;
  localparam longint XTAL_WAKE_US = 16;
  localparam logic [17:0] RC_CAL_CYC  = 18'((CLK_HZ * RC_CAL_MS + 999) / 1000);
  localparam logic [31:0] RC_FINE_CYC = 32'(CLK_HZ * RC_FINE_S);
  localparam logic [11:0] VCO_MEAS_CYC =
    12'((CLK_HZ * VCO_MEAS_US + 999_999) / 1_000_000);
  localparam logic [11:0] VCO_MEAS_DBL = 12'(2 * VCO_MEAS_CYC);
  localparam logic [10:0] XTAL_WAKE_CYC =
    11'((CLK_HZ * XTAL_WAKE_US + 999_999) / 1_000_000);
  localparam logic [10:0] XTAL_HALF_CYC = 11'(XTAL_WAKE_CYC / 2);

  // ------------------------------------------------------------------
  // State types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {RC_IDLE = 2'b01, RC_RUN = 2'b10} rc_state_t;
  typedef enum logic [1:0] {VCO_IDLE = 2'b01, VCO_MEAS = 2'b10} vco_state_t;

endpackage

// [hw/rc_cal_timer.sv]
// RC oscillator calibration sequencer: forced, automatic and periodic fine runs.
`timescale 1ns/1ns
module rc_cal_timer #(
  parameter logic [17:0] CAL_CYC  = radio_cal_pkg::RC_CAL_CYC,
  parameter logic [31:0] FINE_CYC = radio_cal_pkg::RC_FINE_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Requests
  input  wire logic osc_en,
  input  wire logic force_req,
  input  wire logic auto_cond,
  input  wire logic fine_en,
  // Status
  output logic      cal_busy,
  output logic      cal_fine,
  output logic      cal_done
);

  radio_cal_pkg::rc_state_t state_q, state_d;
  logic [17:0] cnt_q,  cnt_d;
  logic [31:0] fine_q, fine_d;
  logic        auto_q, auto_d;
  logic        apend_q, apend_d;
  logic        fpend_q, fpend_d;
  logic        frun_q, frun_d;
  logic        done_q, done_d;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  // An auto or fine request that arrives during a run waits and is served next; a force set during a run is cleared at its end.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    fine_d  = fine_q;
    auto_d  = auto_cond;
    apend_d = apend_q;
    fpend_d = fpend_q;
    frun_d  = frun_q;
    done_d  = 1'b0;
    unique case (state_q)
      radio_cal_pkg::RC_IDLE: begin
        // The done flag blocks a restart while the force bit is being cleared.
        if (osc_en && !done_q && (force_req || apend_q || fpend_q)) begin // R07
          state_d = radio_cal_pkg::RC_RUN;
          cnt_d   = 18'd0;
          frun_d  = !force_req && !apend_q;
          apend_d = 1'b0;
          fpend_d = 1'b0;
        end
      end
      radio_cal_pkg::RC_RUN: begin
        if (cnt_q == CAL_CYC - 18'd1) begin // R05
          state_d = radio_cal_pkg::RC_IDLE;
          done_d  = 1'b1;
          frun_d  = 1'b0;
        end else begin
          cnt_d = cnt_q + 18'd1;
        end
      end
    endcase
    // Periodic fine timer runs only while enabled and the oscillator runs.
    // It follows the state logic so that a wrap in a start cycle is not lost.
    if (fine_en && osc_en) begin // R03
      if (fine_q == FINE_CYC - 32'd1) begin
        fine_d  = 32'd0;
        fpend_d = 1'b1;
      end else begin
        fine_d = fine_q + 32'd1;
      end
    end else begin
      fine_d  = 32'd0;
      fpend_d = 1'b0;
    end
    // Entering wake-up timer or wake-on-receive asks for a run; set wins.
    if (auto_cond && !auto_q) begin // R06
      apend_d = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= radio_cal_pkg::RC_IDLE;
      cnt_q   <= 18'd0;
      fine_q  <= 32'd0;
      auto_q  <= 1'b0;
      apend_q <= 1'b0;
      fpend_q <= 1'b0;
      frun_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      fine_q  <= fine_d;
      auto_q  <= auto_d;
      apend_q <= apend_d;
      fpend_q <= fpend_d;
      frun_q  <= frun_d;
      done_q  <= done_d;
    end
  end

  assign cal_busy = (state_q == radio_cal_pkg::RC_RUN);
  assign cal_fine = frun_q;
  assign cal_done = done_q;

endmodule

// [hw/radio_calibration_control.sv]
// Calibration control, modem test and charge pump test registers with their sequencers.
`timescale 1ns/1ns
module radio_calibration_control #(
  parameter logic [17:0] RC_CAL_CYC  = radio_cal_pkg::RC_CAL_CYC,
  parameter logic [31:0] RC_FINE_CYC = radio_cal_pkg::RC_FINE_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Device state
  input  wire logic       chip_idle,
  input  wire logic       pll_on,
  input  wire logic       rc_osc_en,
  input  wire logic       wut_en,
  input  wire logic       wor_state,
  input  wire logic       adc_cal_done,
  input  wire logic       idle_to_txrx,
  // Calibration outputs
  output logic            rc_cal_busy,
  output logic            rc_cal_fine,
  output logic            vco_cal_gate,
  output logic            vco_cal_long,
  output logic            vco_cal_done,
  output logic            txrx_enter,
  // Crystal wake
  input  wire logic       xtal_wake_start,
  output logic            xtal_ready,
  // Modem controls
  output logic            bcr_phase_bypass,
  output logic            slicer_phase_bypass,
  output logic            afc_polarity,
  output logic            dsm_ref_sel_10m,
  output logic            dsm_ref_invert,
  input  wire logic       dither_en,
  input  wire logic       dither_rnd,
  output logic      [1:0] dither_inc,
  input  wire logic [7:0] rx_i_in,
  input  wire logic [7:0] rx_q_in,
  output logic      [7:0] rx_i_out,
  output logic      [7:0] rx_q_out,
  // Charge pump controls
  output logic            pfd_rst,
  output logic            fbdiv_rst,
  output logic            cp_force_up,
  output logic            cp_force_dn,
  output logic            cp_dc_only,
  output logic      [2:0] cp_dc_current
);

  logic [7:0] cal_q, cal_d, modem_q, modem_d, cp_q, cp_d, rdata_q, rdata_d;
  logic       wr_cal, rc_done, vco_end;
  logic       rc_bit, vco_bit;
  radio_cal_pkg::vco_state_t vst_q, vst_d;
  logic [11:0] vcnt_q, vcnt_d, vlen_q, vlen_d;
  logic        vtrans_q, vtrans_d, vlong_q, vlong_d, vdone_q, vdone_d, enter_q, enter_d;
  logic [10:0] xcnt_q, xcnt_d;
  logic        xrun_q, xrun_d, xrdy_q, xrdy_d;
  logic [1:0]  dith_q, dith_d;
  logic [7:0]  iout_q, iout_d, qout_q, qout_d;

  assign wr_cal  = reg_wr_en && (reg_addr == radio_cal_pkg::ADDR_CAL);
  assign vco_end = (vst_q == radio_cal_pkg::VCO_MEAS) && (vcnt_q == vlen_q - 12'd1);

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  // Hardware clears are applied first so that rewriting 1 in the same cycle cannot undo them.
  always_comb begin
    cal_d   = cal_q;
    modem_d = modem_q;
    cp_d    = cp_q;
    rdata_d = rdata_q;
    if (rc_done || (cal_q[radio_cal_pkg::CAL_RCF] && !rc_osc_en)) begin // R04 R07
      cal_d[radio_cal_pkg::CAL_RCF] = 1'b0;
    end
    if (vco_end) begin // R09
      cal_d[radio_cal_pkg::CAL_VCOF] = 1'b0;
    end
    rc_bit  = cal_d[radio_cal_pkg::CAL_RCF];
    vco_bit = cal_d[radio_cal_pkg::CAL_VCOF];
    if (wr_cal) begin
      cal_d = reg_wdata & radio_cal_pkg::CAL_WR_MASK;
      // Only a 0-to-1 change starts a run; rewriting 1 keeps the hardware view.
      cal_d[radio_cal_pkg::CAL_RCF] = reg_wdata[radio_cal_pkg::CAL_RCF] &&
        (!cal_q[radio_cal_pkg::CAL_RCF] || rc_bit); // R04
      cal_d[radio_cal_pkg::CAL_VCOF] = reg_wdata[radio_cal_pkg::CAL_VCOF] &&
        (cal_q[radio_cal_pkg::CAL_VCOF] ? vco_bit : (chip_idle && pll_on)); // R09 R22
    end
    if (reg_wr_en && (reg_addr == radio_cal_pkg::ADDR_MODEM)) begin
      modem_d = reg_wdata;
    end
    if (reg_wr_en && (reg_addr == radio_cal_pkg::ADDR_CP)) begin
      cp_d = reg_wdata;
    end
    if (reg_rd_en) begin
      unique case (reg_addr)
        radio_cal_pkg::ADDR_CAL:
          rdata_d = {1'b0, cal_q[6], adc_cal_done, cal_q[4:0]}; // R02
        radio_cal_pkg::ADDR_MODEM: rdata_d = modem_q;
        radio_cal_pkg::ADDR_CP:    rdata_d = cp_q;
        default:                   rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_q   <= radio_cal_pkg::CAL_RST;
      modem_q <= radio_cal_pkg::MODEM_RST;
      cp_q    <= radio_cal_pkg::CP_RST;
      rdata_q <= 8'h00;
    end else begin
      cal_q   <= cal_d;
      modem_q <= modem_d;
      cp_q    <= cp_d;
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------------
  // RC oscillator calibration
  // ------------------------------------------------------------------
  // The force bit stays set for the whole run unless the oscillator turns off or software writes it to 0, and clears at its end.
  rc_cal_timer #(
    .CAL_CYC  (RC_CAL_CYC),
    .FINE_CYC (RC_FINE_CYC)
  ) u_rc (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .osc_en    (rc_osc_en),
    .force_req (cal_q[radio_cal_pkg::CAL_RCF]),
    .auto_cond (wut_en || wor_state),
    .fine_en   (cal_q[radio_cal_pkg::CAL_FINE]),
    .cal_busy  (rc_cal_busy),
    .cal_fine  (rc_cal_fine),
    .cal_done  (rc_done)
  );

  // ------------------------------------------------------------------
  // VCO calibration sequencer
  // ------------------------------------------------------------------
  // A transition request during a running measurement is ignored; the caller waits.
  always_comb begin
    vst_d    = vst_q;
    vcnt_d   = vcnt_q;
    vlen_d   = vlen_q;
    vtrans_d = vtrans_q;
    vlong_d  = vlong_q;
    vdone_d  = 1'b0;
    enter_d  = 1'b0;
    unique case (vst_q)
      radio_cal_pkg::VCO_IDLE: begin
        if (idle_to_txrx && cal_q[radio_cal_pkg::CAL_SKIP]) begin
          enter_d = 1'b1; // R10
        end else if (idle_to_txrx || cal_q[radio_cal_pkg::CAL_VCOF]) begin // R09
          vst_d    = radio_cal_pkg::VCO_MEAS;
          vcnt_d   = 12'd0;
          vlong_d  = cal_q[radio_cal_pkg::CAL_DP];
          vlen_d   = cal_q[radio_cal_pkg::CAL_DP] ? radio_cal_pkg::VCO_MEAS_DBL
                                                  : radio_cal_pkg::VCO_MEAS_CYC; // R08
          vtrans_d = idle_to_txrx;
        end
      end
      radio_cal_pkg::VCO_MEAS: begin
        if (vco_end) begin
          vst_d   = radio_cal_pkg::VCO_IDLE;
          vdone_d = 1'b1;
          enter_d = vtrans_q;
        end else begin
          vcnt_d = vcnt_q + 12'd1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vst_q    <= radio_cal_pkg::VCO_IDLE;
      vcnt_q   <= 12'd0;
      vlen_q   <= radio_cal_pkg::VCO_MEAS_CYC;
      vtrans_q <= 1'b0;
      vlong_q  <= 1'b0;
      vdone_q  <= 1'b0;
      enter_q  <= 1'b0;
    end else begin
      vst_q    <= vst_d;
      vcnt_q   <= vcnt_d;
      vlen_q   <= vlen_d;
      vtrans_q <= vtrans_d;
      vlong_q  <= vlong_d;
      vdone_q  <= vdone_d;
      enter_q  <= enter_d;
    end
  end

  // ------------------------------------------------------------------
  // Crystal wake timer and datapath controls
  // ------------------------------------------------------------------
  // The half-period bit is read live, so changing it mid-wake moves the end point.
  always_comb begin
    xcnt_d = xcnt_q;
    xrun_d = xrun_q;
    xrdy_d = xrdy_q;
    if (xtal_wake_start) begin
      xrun_d = 1'b1;
      xrdy_d = 1'b0;
      xcnt_d = 11'd0;
    end else if (xrun_q) begin
      if (xcnt_q == (cal_q[radio_cal_pkg::CAL_XHALF] ? radio_cal_pkg::XTAL_HALF_CYC
                                                     : radio_cal_pkg::XTAL_WAKE_CYC) - 11'd1) begin
        xrun_d = 1'b0; // R01
        xrdy_d = 1'b1;
      end else begin
        xcnt_d = xcnt_q + 11'd1;
      end
    end
    // Type low gives +1 or 0, type high gives +1 or -1.
    if (!dither_en) begin
      dith_d = 2'b00;
    end else if (modem_q[radio_cal_pkg::MT_DTTYPE]) begin
      dith_d = dither_rnd ? 2'b01 : 2'b11; // R13
    end else begin
      dith_d = dither_rnd ? 2'b01 : 2'b00; // R13
    end
    iout_d = modem_q[radio_cal_pkg::MT_IQSW] ? rx_q_in : rx_i_in; // R17
    qout_d = modem_q[radio_cal_pkg::MT_IQSW] ? rx_i_in : rx_q_in; // R17
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xcnt_q <= 11'd0;
      xrun_q <= 1'b0;
      xrdy_q <= 1'b0;
      dith_q <= 2'b00;
      iout_q <= 8'h00;
      qout_q <= 8'h00;
    end else begin
      xcnt_q <= xcnt_d;
      xrun_q <= xrun_d;
      xrdy_q <= xrdy_d;
      dith_q <= dith_d;
      iout_q <= iout_d;
      qout_q <= qout_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Test bits other than IQ swap and dither type go straight from the register flops; there is no logic in between.
  assign reg_rdata           = rdata_q;
  assign vco_cal_gate        = (vst_q == radio_cal_pkg::VCO_MEAS);
  assign vco_cal_long        = vlong_q;
  assign vco_cal_done        = vdone_q;
  assign txrx_enter          = enter_q;
  assign xtal_ready          = xrdy_q;
  assign bcr_phase_bypass    = modem_q[radio_cal_pkg::MT_BCRBYP]; // R11
  assign slicer_phase_bypass = modem_q[radio_cal_pkg::MT_SLCBYP]; // R12
  assign afc_polarity        = modem_q[radio_cal_pkg::MT_AFCPOL];
  assign dsm_ref_sel_10m     = modem_q[radio_cal_pkg::MT_REFSEL]; // R15
  assign dsm_ref_invert      = modem_q[radio_cal_pkg::MT_REFINV]; // R16
  assign dither_inc          = dith_q;
  assign rx_i_out            = iout_q;
  assign rx_q_out            = qout_q;
  assign pfd_rst             = cp_q[radio_cal_pkg::CP_PFDRST]; // R21
  assign fbdiv_rst           = cp_q[radio_cal_pkg::CP_FBRST]; // R21
  assign cp_force_up         = cp_q[radio_cal_pkg::CP_UP]; // R18
  assign cp_force_dn         = cp_q[radio_cal_pkg::CP_DN]; // R18
  assign cp_dc_only          = cp_q[radio_cal_pkg::CP_DCONLY]; // R20
  assign cp_dc_current       = cp_q[radio_cal_pkg::CP_CUR_HI:0]; // R19

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Helper: length of each VCO measurement gate.
  logic [12:0] gcnt_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gcnt_q <= 13'd0;
    end else begin
      gcnt_q <= vco_cal_gate ? gcnt_q + 13'd1 : 13'd0;
    end
  end

  property p_cp_direct;
    reg_wr_en && reg_addr == radio_cal_pkg::ADDR_CP |=>
      pfd_rst == $past(reg_wdata[7]) && fbdiv_rst == $past(reg_wdata[6]);
  endproperty
  a_cp_direct: assert property (p_cp_direct) else $error("test reset lines wrong"); // R21
  property p_rc_start;
    wr_cal && reg_wdata[3] && !cal_q[3] && rc_osc_en && !rc_cal_busy && !rc_done
      ##1 rc_osc_en |-> ##1 rc_cal_busy;
  endproperty
  a_rc_start: assert property (p_rc_start) else $error("forced RC run not started"); // R04
  property p_rc_refuse;
    cal_q[3] && !rc_osc_en && !wr_cal |=> !cal_q[3];
  endproperty
  a_rc_refuse: assert property (p_rc_refuse) else $error("RC force kept with osc off"); // R07
  property p_vco_refuse;
    wr_cal && reg_wdata[1] && !cal_q[1] && !(chip_idle && pll_on) |=> !cal_q[1];
  endproperty
  a_vco_refuse: assert property (p_vco_refuse) else $error("VCO force accepted"); // R22
  property p_vco_force;
    wr_cal && reg_wdata[1] && !cal_q[1] && chip_idle && pll_on && !vco_cal_gate
      ##1 !idle_to_txrx |=> vco_cal_gate;
  endproperty
  a_vco_force: assert property (p_vco_force) else $error("VCO force run missing"); // R09
  property p_vco_len;
    $fell(vco_cal_gate) |-> gcnt_q == ($past(vco_cal_long) ?
      13'(radio_cal_pkg::VCO_MEAS_DBL) : 13'(radio_cal_pkg::VCO_MEAS_CYC));
  endproperty
  a_vco_len: assert property (p_vco_len) else $error("VCO interval length wrong"); // R08
  property p_skip;
    idle_to_txrx && cal_q[0] && !vco_cal_gate |=> txrx_enter && !vco_cal_gate;
  endproperty
  a_skip: assert property (p_skip) else $error("VCO step not skipped"); // R10
  property p_iq;
    $past(modem_q[0]) |-> rx_i_out == $past(rx_q_in) && rx_q_out == $past(rx_i_in);
  endproperty
  a_iq: assert property (p_iq) else $error("IQ swap wrong"); // R17
  property p_dither;
    dither_en && modem_q[5] && !dither_rnd |=> dither_inc == 2'b11;
  endproperty
  a_dither: assert property (p_dither) else $error("dither increment wrong"); // R13
  property p_adc;
    reg_rd_en && reg_addr == radio_cal_pkg::ADDR_CAL |=> reg_rdata[5] == $past(adc_cal_done);
  endproperty
  a_adc: assert property (p_adc) else $error("ADC done readback wrong"); // R02

  c_rc_run:   cover property (rc_done);
  c_vco_long: cover property ($fell(vco_cal_gate) && vco_cal_long);
  c_skip:     cover property (txrx_enter && !vco_cal_done);
  c_xtal:     cover property ($rose(xtal_ready) && cal_q[6]);

endmodule

// [tb/radio_calibration_control_tb.sv]
// Self-checking bench for the calibration, modem test and charge pump test registers.
`timescale 1ns/1ns
module radio_calibration_control_tb;
  // ------------------------------------------------------------------
  // Signals and counters
  // ------------------------------------------------------------------
  localparam int CAL = 20;
  logic clk, sys_rst, reg_wr_en, reg_rd_en, chip_idle, pll_on, rc_osc_en, wut_en, wor_state;
  logic adc_cal_done, idle_to_txrx, xtal_wake_start, dither_en, dither_rnd;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_i_in, rx_q_in, rx_i_out, rx_q_out, v;
  logic rc_cal_busy, rc_cal_fine, vco_cal_gate, vco_cal_long, vco_cal_done, txrx_enter;
  logic xtal_ready, bcr_phase_bypass, slicer_phase_bypass, afc_polarity, dsm_ref_sel_10m;
  logic dsm_ref_invert, pfd_rst, fbdiv_rst, cp_force_up, cp_force_dn, cp_dc_only;
  logic [1:0] dither_inc;
  logic [2:0] cp_dc_current;
  int fail_count, n_checks, seed, cyc, k;

  // Short calibration counts keep the run brief; expectations use CAL.
  radio_calibration_control #(.RC_CAL_CYC(18'h14), .RC_FINE_CYC(32'hC8))
  radio_calibration_control_inst (
    .clk(clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .chip_idle(chip_idle),
    .pll_on(pll_on), .rc_osc_en(rc_osc_en), .wut_en(wut_en), .wor_state(wor_state),
    .adc_cal_done(adc_cal_done), .idle_to_txrx(idle_to_txrx), .rc_cal_busy(rc_cal_busy),
    .rc_cal_fine(rc_cal_fine), .vco_cal_gate(vco_cal_gate), .vco_cal_long(vco_cal_long),
    .vco_cal_done(vco_cal_done), .txrx_enter(txrx_enter), .xtal_wake_start(xtal_wake_start),
    .xtal_ready(xtal_ready), .bcr_phase_bypass(bcr_phase_bypass),
    .slicer_phase_bypass(slicer_phase_bypass), .afc_polarity(afc_polarity),
    .dsm_ref_sel_10m(dsm_ref_sel_10m), .dsm_ref_invert(dsm_ref_invert), .dither_en(dither_en),
    .dither_rnd(dither_rnd), .dither_inc(dither_inc), .rx_i_in(rx_i_in), .rx_q_in(rx_q_in),
    .rx_i_out(rx_i_out), .rx_q_out(rx_q_out), .pfd_rst(pfd_rst), .fbdiv_rst(fbdiv_rst),
    .cp_force_up(cp_force_up), .cp_force_dn(cp_force_dn), .cp_dc_only(cp_dc_only),
    .cp_dc_current(cp_dc_current));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Clock, and a cycle ceiling well above the longest sequence so a hang ends the run.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask
  // Read data is registered, so it is looked at in the cycle after the strobe.
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  function automatic logic sig(input int w);
    return (w == 0) ? rc_cal_busy : (w == 1) ? vco_cal_gate : !xtal_ready;
  endfunction
  // Waits for a level to rise and counts its high cycles, under a bound.
  task automatic meas(input int w, input int len);
    int n;
    n = 0;
    for (int i = 0; i < 6000; i++) begin
      @(negedge clk);
      if (sig(w)) n++;
      else if (n > 0) break;
    end
    chk(n, len);
  endtask
  task automatic pulse(input int w);
    @(posedge clk);
    if (w == 0) idle_to_txrx <= 1'b1; else xtal_wake_start <= 1'b1;
    @(posedge clk);
    idle_to_txrx    <= 1'b0;
    xtal_wake_start <= 1'b0;
  endtask
  function automatic logic [1:0] dith(input logic en, input logic rnd, input logic typ);
    return !en ? 2'h0 : rnd ? 2'h1 : typ ? 2'h3 : 2'h0;
  endfunction
  task automatic done(input string name);
    $display("test %0s finished", name);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {reg_wr_en, reg_rd_en, wut_en, wor_state, adc_cal_done, idle_to_txrx} = 6'h00;
    {xtal_wake_start, dither_en, dither_rnd, chip_idle} = 4'h0;
    {pll_on, rc_osc_en} = 2'h3;
    {reg_addr, reg_wdata, rx_i_in, rx_q_in} = '0;
    {fail_count, n_checks, cyc} = '0;
    seed = 62;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(7'h55, 8'h04);
    rd(7'h56, 8'h00);
    rd(7'h57, 8'h00);
    rd(7'h54, 8'h00);
    done("reset");
    // The loop polarity bit is never touched by software, so writes keep it at 0.
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      v = (k == 0) ? 8'hEF : 8'($random(seed)) & 8'hEF;
      {rx_i_in, rx_q_in} <= 16'($random(seed));
      {dither_en, dither_rnd} <= (k < 4) ? 2'(k) : 2'($random(seed));
      wr(7'h56, v);
      rd(7'h56, v);
      chk({bcr_phase_bypass, slicer_phase_bypass}, v[7:6]);
      chk({afc_polarity, dsm_ref_sel_10m, dsm_ref_invert}, {v[4], v[2:1]});
      chk({rx_i_out, rx_q_out}, v[0] ? {rx_q_in, rx_i_in} : {rx_i_in, rx_q_in});
      chk(dither_inc, dith(dither_en, dither_rnd, v[5]));
      v = (k == 0) ? 8'hFF : 8'($random(seed));
      wr(7'h57, v);
      rd(7'h57, v);
      chk({pfd_rst, fbdiv_rst, cp_force_up, cp_force_dn}, v[7:4]);
      chk({cp_dc_only, cp_dc_current}, v[3:0]);
    end
    done("modem_cp");
    wr(7'h55, 8'h02);
    rd(7'h55, 8'h00);
    chk(vco_cal_gate, 1'b0);
    @(posedge clk);
    chip_idle <= 1'b1;
    wr(7'h55, 8'h02);
    meas(1, 1250);
    rd(7'h55, 8'h00);
    wr(7'h55, 8'h06);
    meas(1, 2500);
    chk({txrx_enter, vco_cal_done, vco_cal_long}, 3'h3);
    wr(7'h55, 8'h01);
    pulse(0);
    @(negedge clk);
    chk({txrx_enter, vco_cal_gate}, 2'h2);
    wr(7'h55, 8'h00);
    pulse(0);
    meas(1, 1250);
    chk({txrx_enter, vco_cal_done, vco_cal_long}, 3'h6);
    done("vco");
    wr(7'h55, 8'h08);
    meas(0, CAL);
    rd(7'h55, 8'h00);
    @(posedge clk);
    rc_osc_en <= 1'b0;
    wr(7'h55, 8'h08);
    repeat (3) @(posedge clk);
    rd(7'h55, 8'h00);
    chk(rc_cal_busy, 1'b0);
    @(posedge clk);
    rc_osc_en <= 1'b1;
    wor_state <= 1'b1;
    meas(0, CAL);
    @(posedge clk);
    wor_state <= 1'b0;
    @(posedge clk);
    wut_en <= 1'b1;
    meas(0, CAL);
    wr(7'h55, 8'h10);
    for (k = 0; k < 600 && rc_cal_fine !== 1'b1; k++) @(negedge clk);
    chk(rc_cal_fine, 1'b1);
    done("rc");
    @(posedge clk);
    adc_cal_done <= 1'b1;
    wr(7'h55, 8'hA0);
    rd(7'h55, 8'h20);
    wr(7'h55, 8'h00);
    pulse(1);
    meas(2, 2000);
    wr(7'h55, 8'h40);
    pulse(1);
    meas(2, 1000);
    done("crystal_adc");
    wrap_up();
  end
endmodule
